// [hdl/mrs_reset_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
module mrs_reset_sequencer (
  // Clock and power-up reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Oscillator and option bits
  input wire logic osc_ready_i,
  input wire logic opt_long_delay_i,
  input wire logic opt_watchdog_en_i,
  // Internal reset requests
  input wire logic watchdog_timeout_i,
  input wire logic fetch_valid_i,
  input wire logic [15:0] fetch_addr_i,
  // Reset pin
  input wire logic reset_pin_n_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_n_o,
  // System reset and restart hints
  output logic sys_rst_o,
  output logic set_imask_o,
  output logic [15:0] vec_hi_addr_o,
  output logic [15:0] vec_lo_addr_o
);
  logic pin_meta_reg, pin_meta_next;
  logic pin_sync_reg, pin_sync_next;
  mrs_pkg::mrs_por_e por_state_reg, por_state_next;
  logic [mrs_pkg::POR_CNT_W-1:0] por_cnt_reg, por_cnt_next;
  logic wdt_pulse_reg, wdt_pulse_next;
  logic ilf_pulse_reg, ilf_pulse_next;
  logic rst_latch_reg, rst_latch_next;
  logic imask_reg, imask_next;
  logic [mrs_pkg::POR_CNT_W-1:0] por_target;
  logic illegal_hit;
  mrs_pkg::mrs_src_s src;
  logic [mrs_pkg::POR_CNT_W-1:0] chk_por_len_reg, chk_por_len_next;

  assign por_target = opt_long_delay_i ? mrs_pkg::POR_CNT_W'(mrs_pkg::POR_LONG_CYCLES) :
                      mrs_pkg::POR_CNT_W'(mrs_pkg::POR_SHORT_CYCLES);
  assign illegal_hit = fetch_valid_i && (fetch_addr_i >= mrs_pkg::IO_AREA_LO) &&
                       (fetch_addr_i <= mrs_pkg::IO_AREA_HI);

  // Two-stage synchroniser on the pin
  always_comb begin
    pin_meta_next = reset_pin_n_i;
    pin_sync_next = pin_meta_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
    end
  end

  // Power-on delay, counted once the oscillator runs
  always_comb begin
    por_state_next = por_state_reg;
    por_cnt_next = por_cnt_reg;
    case (por_state_reg)
      mrs_pkg::MRS_POR_WAIT_OSC: begin
        por_cnt_next = '0;
        if (osc_ready_i) begin
          por_state_next = mrs_pkg::MRS_POR_COUNT;
        end
      end
      mrs_pkg::MRS_POR_COUNT: begin
        por_cnt_next = por_cnt_reg + 1'b1;
        if (por_cnt_reg + 1'b1 >= por_target) begin
          por_state_next = mrs_pkg::MRS_POR_DONE;
        end
      end
      mrs_pkg::MRS_POR_DONE: begin
        por_cnt_next = por_cnt_reg;
      end
      default: begin
        por_state_next = mrs_pkg::MRS_POR_WAIT_OSC;
        por_cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      por_state_reg <= mrs_pkg::MRS_POR_WAIT_OSC;
      por_cnt_reg <= '0;
    end else begin
      por_state_reg <= por_state_next;
      por_cnt_reg <= por_cnt_next;
    end
  end

  // Single-cycle internal reset pulses, also drive the pin pulldown
  always_comb begin
    wdt_pulse_next = opt_watchdog_en_i && watchdog_timeout_i && !wdt_pulse_reg;
    ilf_pulse_next = illegal_hit && !ilf_pulse_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wdt_pulse_reg <= 1'b0;
      ilf_pulse_reg <= 1'b0;
    end else begin
      wdt_pulse_reg <= wdt_pulse_next;
      ilf_pulse_reg <= ilf_pulse_next;
    end
  end

  // Any active source keeps the latch set
  always_comb begin
    src.ext_pin = !pin_sync_reg;
    src.por = (por_state_reg != mrs_pkg::MRS_POR_DONE);
    src.watchdog = wdt_pulse_reg;
    src.illegal_fetch = ilf_pulse_reg;
    rst_latch_next = |src;
    imask_next = imask_reg;
    if (rst_latch_reg) begin
      imask_next = 1'b1;
    end else begin
      imask_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rst_latch_reg <= 1'b1;
      imask_reg <= 1'b1;
    end else begin
      rst_latch_reg <= rst_latch_next;
      imask_reg <= imask_next;
    end
  end

  assign sys_rst_o = rst_latch_reg;
  assign set_imask_o = imask_reg;
  assign vec_hi_addr_o = mrs_pkg::RESET_VEC_HI;
  assign vec_lo_addr_o = mrs_pkg::RESET_VEC_LO;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n_o = !(wdt_pulse_reg || ilf_pulse_reg);

  property p_wdt_one_cycle;
    @(posedge clk_sys_i) disable iff (srst_i)
      $fell(reset_pin_oe_n_o) |=> reset_pin_oe_n_o;
  endproperty
  a_wdt_one_cycle: assert property (p_wdt_one_cycle) else $error("pulldown longer than one cycle");

  property p_wdt_causes_pull;
    @(posedge clk_sys_i) disable iff (srst_i)
      (opt_watchdog_en_i && watchdog_timeout_i && !wdt_pulse_reg) |=> !reset_pin_oe_n_o;
  endproperty
  a_wdt_causes_pull: assert property (p_wdt_causes_pull) else $error("watchdog did not pull pin");

  property p_ilf_pull;
    @(posedge clk_sys_i) disable iff (srst_i)
      (illegal_hit && !ilf_pulse_reg) |=> (!reset_pin_oe_n_o ##1 sys_rst_o);
  endproperty
  a_ilf_pull: assert property (p_ilf_pull) else $error("illegal fetch reset missing");

  property p_ilf_range;
    @(posedge clk_sys_i) disable iff (srst_i)
      (fetch_valid_i && fetch_addr_i == 16'h0020 && !ilf_pulse_reg) |=> !ilf_pulse_reg;
  endproperty
  a_ilf_range: assert property (p_ilf_range) else $error("fetch above I/O area flagged");

  property p_pin_holds;
    @(posedge clk_sys_i) disable iff (srst_i)
      (!pin_sync_reg) |=> sys_rst_o;
  endproperty
  a_pin_holds: assert property (p_pin_holds) else $error("reset not held by low pin");

  // Check helper: cycles spent in the counting state
  always_comb begin
    chk_por_len_next = '0;
    if (por_state_reg == mrs_pkg::MRS_POR_COUNT) begin
      chk_por_len_next = chk_por_len_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      chk_por_len_reg <= '0;
    end else begin
      chk_por_len_reg <= chk_por_len_next;
    end
  end

  property p_por_len;
    @(posedge clk_sys_i) disable iff (srst_i)
      (por_state_reg == mrs_pkg::MRS_POR_DONE && $past(por_state_reg) == mrs_pkg::MRS_POR_COUNT) |->
        (chk_por_len_reg == (opt_long_delay_i ? mrs_pkg::POR_CNT_W'(mrs_pkg::POR_LONG_CYCLES) :
                             mrs_pkg::POR_CNT_W'(mrs_pkg::POR_SHORT_CYCLES)));
  endproperty
  a_por_len: assert property (p_por_len) else $error("power-on delay wrong");

  property p_por_held;
    @(posedge clk_sys_i) disable iff (srst_i)
      (por_state_reg != mrs_pkg::MRS_POR_DONE) |=> sys_rst_o;
  endproperty
  a_por_held: assert property (p_por_held) else $error("reset released during power-on");

  property p_release;
    @(posedge clk_sys_i) disable iff (srst_i)
      $fell(sys_rst_o) |-> $past(src) == '0;
  endproperty
  a_release: assert property (p_release) else $error("released with source active");

  property p_imask;
    @(posedge clk_sys_i) disable iff (srst_i)
      $fell(sys_rst_o) |-> set_imask_o;
  endproperty
  a_imask: assert property (p_imask) else $error("interrupt mask not set at release");

  property p_any_src;
    @(posedge clk_sys_i) disable iff (srst_i)
      (src != '0) |=> sys_rst_o;
  endproperty
  a_any_src: assert property (p_any_src) else $error("active source did not hold reset");

  property p_idle_release;
    @(posedge clk_sys_i) disable iff (srst_i)
      (src == '0) |=> !sys_rst_o;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("reset kept with no source");

  property p_rst_cause;
    @(posedge clk_sys_i) disable iff (srst_i)
      $rose(sys_rst_o) |-> ($past(src) != '0);
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("reset raised without source");

  property p_wdt_off;
    @(posedge clk_sys_i) disable iff (srst_i)
      !opt_watchdog_en_i |=> !wdt_pulse_reg;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog reset while disabled");

  property p_wdt_single;
    @(posedge clk_sys_i) disable iff (srst_i)
      wdt_pulse_reg |=> !wdt_pulse_reg;
  endproperty
  a_wdt_single: assert property (p_wdt_single) else $error("watchdog pulse too long");

  property p_ilf_single;
    @(posedge clk_sys_i) disable iff (srst_i)
      ilf_pulse_reg |=> !ilf_pulse_reg;
  endproperty
  a_ilf_single: assert property (p_ilf_single) else $error("illegal fetch pulse too long");

  property p_ilf_hit;
    @(posedge clk_sys_i) disable iff (srst_i)
      (fetch_valid_i && fetch_addr_i <= mrs_pkg::IO_AREA_HI && !ilf_pulse_reg) |=> ilf_pulse_reg;
  endproperty
  a_ilf_hit: assert property (p_ilf_hit) else $error("fetch in I/O area not flagged");

  property p_osc_wait;
    @(posedge clk_sys_i) disable iff (srst_i)
      (por_state_reg == mrs_pkg::MRS_POR_WAIT_OSC && !osc_ready_i) |=> (por_state_reg == mrs_pkg::MRS_POR_WAIT_OSC);
  endproperty
  a_osc_wait: assert property (p_osc_wait) else $error("delay started before oscillator");

  property p_por_final;
    @(posedge clk_sys_i) disable iff (srst_i)
      (por_state_reg == mrs_pkg::MRS_POR_DONE) |=> (por_state_reg == mrs_pkg::MRS_POR_DONE);
  endproperty
  a_por_final: assert property (p_por_final) else $error("power-on delay restarted");

  property p_imask_in_rst;
    @(posedge clk_sys_i) disable iff (srst_i)
      sys_rst_o |=> set_imask_o;
  endproperty
  a_imask_in_rst: assert property (p_imask_in_rst) else $error("interrupt mask clear in reset");

  property p_pull_value;
    @(posedge clk_sys_i) disable iff (srst_i)
      !reset_pin_oe_n_o |-> !reset_pin_o;
  endproperty
  a_pull_value: assert property (p_pull_value) else $error("pin driven high");

  property p_pin_sync;
    @(posedge clk_sys_i) disable iff (srst_i)
      !pin_meta_reg |=> !pin_sync_reg;
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("pin synchroniser lost low level");

  c_wdt: cover property (@(posedge clk_sys_i) disable iff (srst_i) wdt_pulse_reg ##1 !sys_rst_o);
  c_ilf: cover property (@(posedge clk_sys_i) disable iff (srst_i) ilf_pulse_reg && !pin_sync_reg);
  c_release: cover property (@(posedge clk_sys_i) disable iff (srst_i) $fell(sys_rst_o));
  c_por_long: cover property (@(posedge clk_sys_i) disable iff (srst_i) opt_long_delay_i && $fell(sys_rst_o));
  c_wdt_pin: cover property (@(posedge clk_sys_i) disable iff (srst_i) wdt_pulse_reg && !pin_sync_reg);
endmodule : mrs_reset_sequencer
`default_nettype wire

// [inc/mrs_pkg.sv]
`default_nettype none
package mrs_pkg;
  // Power-on stabilization counts, in bus clock cycles
  localparam int unsigned POR_SHORT_CYCLES = 16;
  localparam int unsigned POR_LONG_CYCLES = 4064;
  localparam int unsigned POR_CNT_W = 12;
  // I/O address area for illegal fetch detection
  localparam logic [15:0] IO_AREA_LO = 16'h0000;
  localparam logic [15:0] IO_AREA_HI = 16'h001F;
  // Reset vector location
  localparam logic [15:0] RESET_VEC_HI = 16'h03FE;
  localparam logic [15:0] RESET_VEC_LO = 16'h03FF;
  // Pin pulldown pulse length for internal resets
  localparam int unsigned PULLDOWN_CYCLES = 1;

  typedef enum logic [1:0] {
    MRS_POR_WAIT_OSC,
    MRS_POR_COUNT,
    MRS_POR_DONE
  } mrs_por_e;

  typedef struct packed {
    logic ext_pin;
    logic por;
    logic watchdog;
    logic illegal_fetch;
  } mrs_src_s;
endpackage : mrs_pkg
`default_nettype wire

// [test/mrs_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mrs_pin_model (
  // Board reset circuit
  input wire logic hold_low_i,
  // Device pulldown
  input wire logic pin_drv_i,
  input wire logic pin_oe_n_i,
  output logic pin_n_o
);
  // Pull-up on the pin; board or device pulldown wins
  assign pin_n_o = ~(hold_low_i | (~pin_oe_n_i & ~pin_drv_i));
endmodule : mrs_pin_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_sys_i = 0, srst_i = 1, osc = 0, opt_long = 0, wd_en = 0, wd = 0, fv = 0, hold = 0;
  logic [15:0] fa = 16'h0000, r, vh, vl;
  logic pin_n, pin_o, oe_n, sys_rst, imask;
  int miscompares = 0, check_count = 0, seed = 36, n;
  mrs_reset_sequencer i_mrs_reset_sequencer (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .osc_ready_i(osc), .opt_long_delay_i(opt_long), .opt_watchdog_en_i(wd_en),
    .watchdog_timeout_i(wd), .fetch_valid_i(fv), .fetch_addr_i(fa), .reset_pin_n_i(pin_n),
    .reset_pin_o(pin_o), .reset_pin_oe_n_o(oe_n), .sys_rst_o(sys_rst), .set_imask_o(imask),
    .vec_hi_addr_o(vh), .vec_lo_addr_o(vl));
  mrs_pin_model i_mrs_pin_model (.hold_low_i(hold), .pin_drv_i(pin_o), .pin_oe_n_i(oe_n),
    .pin_n_o(pin_n));
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic compare_int(input int got, input int lo, input int hi, input string msg);
    check_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("wrong value at %0t: %s %0d", $time, msg, got);
    end
  endtask : compare_int
  task automatic compare_bit(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : compare_bit
  task automatic wait_clear(output int cnt);
    cnt = 0;
    while (sys_rst !== 1'b0 && cnt < 5000) begin
      @(negedge clk_sys_i);
      cnt++;
    end
    if (cnt >= 5000) begin
      miscompares++;
      $display("wrong value at %0t: system reset never released", $time);
    end
  endtask : wait_clear
  // Model: pulldown and reset expected from the rules alone
  function automatic int model_pull(input logic is_f, input logic [15:0] a, input logic en);
    if (is_f) begin
      return int'(a <= mrs_pkg::IO_AREA_HI);
    end
    return int'(en);
  endfunction : model_pull
  // Model: legal request gives one pulldown cycle and raises reset
  task automatic fire(input logic is_f, input logic [15:0] a, input logic en, input int legal);
    int low = 0;
    int hi = 0;
    int exp_pull;
    exp_pull = model_pull(is_f, a, en);
    @(posedge clk_sys_i);
    wd_en <= en;
    fa <= a;
    fv <= is_f;
    wd <= ~is_f;
    @(posedge clk_sys_i);
    fv <= 1'b0;
    wd <= 1'b0;
    repeat (6) begin
      @(negedge clk_sys_i);
      low += int'(oe_n === 1'b0);
      hi += int'(sys_rst === 1'b1);
    end
    compare_int(low, exp_pull, exp_pull, "pulldown cycles");
    compare_int(int'(hi != 0), exp_pull, exp_pull, "reset raised");
    compare_int(legal, exp_pull, exp_pull, "scenario class");
  endtask : fire
  initial begin
    for (int l = 0; l < 2; l++) begin
      @(posedge clk_sys_i);
      srst_i <= 1'b1;
      osc <= 1'b0;
      opt_long <= l[0];
      repeat (20) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      repeat (5) @(negedge clk_sys_i);
      compare_bit(sys_rst, 1'b1, "reset before osc");
      compare_bit(imask, 1'b1, "mask in reset");
      @(posedge clk_sys_i);
      osc <= 1'b1;
      wait_clear(n);
      compare_int(n, l ? mrs_pkg::POR_LONG_CYCLES : mrs_pkg::POR_SHORT_CYCLES,
        (l ? mrs_pkg::POR_LONG_CYCLES : mrs_pkg::POR_SHORT_CYCLES) + 5, "power-on delay");
      $display("power-on test %0d done", l);
    end
    compare_bit(vh === 16'h03FE && vl === 16'h03FF, 1'b1, "vector");
    fire(1'b1, 16'h001F, 1'b0, 1);
    wait_clear(n);
    fire(1'b1, 16'h0020, 1'b0, 0);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      fire(1'b1, i[0] ? {11'h000, r[4:0]} : (r | 16'h0020), 1'b0, i % 2);
      wait_clear(n);
    end
    fire(1'b0, 16'h0000, 1'b0, 0);
    fire(1'b0, 16'h0000, 1'b1, 1);
    wait_clear(n);
    $display("internal source test done");
    @(posedge clk_sys_i);
    hold <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    fire(1'b1, 16'h0005, 1'b0, 1);
    fire(1'b0, 16'h0000, 1'b1, 1);
    compare_bit(sys_rst, 1'b1, "held by pin");
    @(posedge clk_sys_i);
    hold <= 1'b0;
    wait_clear(n);
    compare_int(n, 1, 8, "pin release");
    $display("pin test done");
    close_out();
  end
  initial begin
    #(12000 * 50);
    miscompares++;
    close_out();
  end
endmodule : tb
`default_nettype wire
